// ---- frp_defines.vh ----
/*
 * Constants of the flash reset and parameter-read command block:
 * opcodes, parameter header contents, recovery times and widths.
 * Assumes it is included by bare name from the frp design files.
 */
`ifndef FRP_DEFINES_VH
`define FRP_DEFINES_VH

// Opcodes
`define FRP_OP_ARM      8'h66
`define FRP_OP_RESET    8'h99
`define FRP_OP_QEXIT    8'hF5
`define FRP_OP_QENTRY   8'h35
`define FRP_OP_NOP      8'h00
`define FRP_OP_PREAD    8'h5A

// Frame lengths in bits, address length in bytes
`define FRP_BYTE_BITS   4'h8
`define FRP_ADDR_BYTES  2'h3
`define FRP_SINGLE_STEP 4'h1
`define FRP_QUAD_STEP   4'h4

// Parameter header byte offsets
`define FRP_PA_SIG0     5'h00
`define FRP_PA_SIG1     5'h01
`define FRP_PA_SIG2     5'h02
`define FRP_PA_SIG3     5'h03
`define FRP_PA_MINOR    5'h04
`define FRP_PA_MAJOR    5'h05
`define FRP_PA_NHDR     5'h06
`define FRP_PA_H0_ID    5'h08
`define FRP_PA_H0_MIN   5'h09
`define FRP_PA_H0_MAJ   5'h0A
`define FRP_PA_H0_LEN   5'h0B
`define FRP_PA_H0_PTR0  5'h0C
`define FRP_PA_H1_ID    5'h10
`define FRP_PA_H1_MIN   5'h11
`define FRP_PA_H1_MAJ   5'h12
`define FRP_PA_H1_LEN   5'h13
`define FRP_PA_H1_PTR0  5'h14

// Parameter header contents
`define FRP_SIG_B0      8'h53
`define FRP_SIG_B1      8'h46
`define FRP_SIG_B2      8'h44
`define FRP_SIG_B3      8'h50
`define FRP_REV_MINOR   8'h00
`define FRP_REV_MAJOR   8'h01
`define FRP_NHDR_VAL    8'h01
`define FRP_STD_ID      8'h00
`define FRP_H0_LEN_VAL  8'h09
`define FRP_H0_PTR_VAL  8'h30
`define FRP_H1_LEN_VAL  8'h04
`define FRP_H1_PTR_VAL  8'h60
`define FRP_PTR_HI      8'h00
`define FRP_UNUSED      8'hFF

// Recovery times and system clock rate
`define FRP_SYS_MHZ      50
`define FRP_RCV_PROG_NS  30000
`define FRP_RCV_OTHER_NS 12000

`endif

// ---- frp_sync.v ----
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_i.
 */
`timescale 1ns/1ps
module frp_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// Data
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta;

	// First stage feeds only the second
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= INIT;
			q_o  <= INIT;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule // frp_sync

// ---- frp_fifo.v ----
/*
 * Small synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/1ps
module frp_fifo #(
	parameter W  = 8,
	parameter AW = 3
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         flush_i,
	// Fill side
	input  wire         wr_valid_i,
	output wire         wr_ready_o,
	input  wire [W-1:0] wr_data_i,
	// Drain side
	output wire         rd_valid_o,
	input  wire         rd_ready_i,
	output wire [W-1:0] rd_data_o
);
	localparam DEPTH = 1 << AW;

	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0]  wp;
	reg [AW:0]  rp;
	wire        full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	wire        empty = (wp == rp);
	wire        do_wr = wr_valid_i && !full;
	wire        do_rd = rd_ready_i && !empty;

	assign wr_ready_o = !full;
	assign rd_valid_o = !empty;
	assign rd_data_o  = mem[rp[AW-1:0]];

	// Storage has no reset; pointers alone define contents
	always @(posedge clk_i) begin
		if (do_wr) begin
			mem[wp[AW-1:0]] <= wr_data_i;
		end
	end

	// Pointers, flush wins over traffic
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp <= {(AW+1){1'b0}};
			rp <= {(AW+1){1'b0}};
		end else if (flush_i) begin
			wp <= {(AW+1){1'b0}};
			rp <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wp <= wp + 1'b1;
			end
			if (do_rd) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule // frp_fifo

// ---- frp_top.v ----
/*
 * Serial flash command front end: two-step software reset, four-wire
 * mode entry and exit, and the parameter header read with its byte stream.
 * Assumes pins arrive asynchronously and the serial clock is at most a
 * quarter of the system clock; array busy and suspend flags are on CLK_SYS_I.
 */
`timescale 1ns/1ps
`include "frp_defines.vh"
module frp_top #(
	parameter [7:0] VENDOR_ID = 8'hA5 // arbitrary value
) (
	// System clock and reset
	input  wire       CLK_SYS_I,
	input  wire       SYS_RST_I,
	// Serial pins
	input  wire       SCLK_I,
	input  wire       CS_N_I,
	input  wire [3:0] SIO_I,
	output reg  [3:0] SIO_O,
	output reg  [3:0] SIO_OE_O,
	// Array core status
	input  wire       PROG_BUSY_I,
	input  wire       ERASE_BUSY_I,
	input  wire       ERASE_SUSP_I,
	// Status towards the core
	output reg        ABORT_O,
	output reg        BUSY_O,
	output reg        QUAD_MODE_O,
	output reg        RESET_DONE_O
);
	// Frame states
	localparam [2:0] ST_CMD   = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_DUMMY = 3'h2;
	localparam [2:0] ST_DATA  = 3'h3;
	localparam [2:0] ST_DONE  = 3'h4;

	// Recovery counts, rounded down from ns at the system rate;
	// worked out at full integer width, then cut to the counter's 16 bits
	localparam [31:0] RCV_PROG_FULL  = `FRP_RCV_PROG_NS * `FRP_SYS_MHZ / 1000;
	localparam [31:0] RCV_OTHER_FULL = `FRP_RCV_OTHER_NS * `FRP_SYS_MHZ / 1000;
	localparam [15:0] RCV_PROG_CYC   = RCV_PROG_FULL[15:0];
	localparam [15:0] RCV_OTHER_CYC  = RCV_OTHER_FULL[15:0];

	// Synchronised pins
	wire       sclk_s;
	wire       cs_n_s;
	wire [3:0] sio_s;
	reg        sclk_d;
	reg        cs_n_d;

	// Every pin crosses here; nothing else reads the first stage
	frp_sync #(
		.W    (6),
		.INIT (6'h02)
	) u_sync (
		.clk_i (CLK_SYS_I),
		.rst_i (SYS_RST_I),
		.d_i   ({SIO_I, CS_N_I, SCLK_I}),
		.q_o   ({sio_s, cs_n_s, sclk_s})
	);

	// Edge history of the synchronised pins
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	wire sck_rise = sclk_s && !sclk_d;
	wire sck_fall = !sclk_s && sclk_d;
	wire cs_rise  = cs_n_s && !cs_n_d;

	// Frame and command state
	reg [2:0]  state;
	reg [7:0]  in_sr;
	reg [3:0]  bit_cnt;
	reg [1:0]  addr_cnt;
	reg [7:0]  opcode;
	reg        op_ok;
	reg        extra;
	reg        armed;
	reg        quad;
	reg [15:0] rcv_cnt;
	reg        rcv_busy;
	reg [23:0] fetch_addr;
	reg        fetch_on;
	reg [7:0]  out_sr;
	reg [3:0]  out_cnt;

	// Bits taken per serial clock depend on the mode
	wire [3:0] step     = quad ? `FRP_QUAD_STEP : `FRP_SINGLE_STEP;
	wire [3:0] next_cnt = bit_cnt + step;
	wire [7:0] next_sr  = quad ? {in_sr[3:0], sio_s} : {in_sr[6:0], sio_s[0]};
	wire       byte_end = sck_rise && (next_cnt == `FRP_BYTE_BITS);
	// Frames are ignored during recovery, so treat the bus as idle
	wire       active   = !cs_n_s && !rcv_busy;

	// Parameter header contents
	function [7:0] hdr_byte;
		input [23:0] a;
		begin
			hdr_byte = `FRP_UNUSED;
			// Only the first 32 bytes carry header data
			if (a[23:5] == 19'h0_0000) begin
				case (a[4:0])
				`FRP_PA_SIG0:   hdr_byte = `FRP_SIG_B0;
				`FRP_PA_SIG1:   hdr_byte = `FRP_SIG_B1;
				`FRP_PA_SIG2:   hdr_byte = `FRP_SIG_B2;
				`FRP_PA_SIG3:   hdr_byte = `FRP_SIG_B3;
				`FRP_PA_MINOR:  hdr_byte = `FRP_REV_MINOR;
				`FRP_PA_MAJOR:  hdr_byte = `FRP_REV_MAJOR;
				`FRP_PA_NHDR:   hdr_byte = `FRP_NHDR_VAL;
				`FRP_PA_H0_ID:  hdr_byte = `FRP_STD_ID;
				`FRP_PA_H0_MIN: hdr_byte = `FRP_REV_MINOR;
				`FRP_PA_H0_MAJ: hdr_byte = `FRP_REV_MAJOR;
				`FRP_PA_H0_LEN: hdr_byte = `FRP_H0_LEN_VAL;
				`FRP_PA_H0_PTR0: hdr_byte = `FRP_H0_PTR_VAL;
				`FRP_PA_H0_PTR0 + 5'h01: hdr_byte = `FRP_PTR_HI;
				`FRP_PA_H0_PTR0 + 5'h02: hdr_byte = `FRP_PTR_HI;
				`FRP_PA_H1_ID:  hdr_byte = VENDOR_ID;
				`FRP_PA_H1_MIN: hdr_byte = `FRP_REV_MINOR;
				`FRP_PA_H1_MAJ: hdr_byte = `FRP_REV_MAJOR;
				`FRP_PA_H1_LEN: hdr_byte = `FRP_H1_LEN_VAL;
				`FRP_PA_H1_PTR0: hdr_byte = `FRP_H1_PTR_VAL;
				`FRP_PA_H1_PTR0 + 5'h01: hdr_byte = `FRP_PTR_HI;
				`FRP_PA_H1_PTR0 + 5'h02: hdr_byte = `FRP_PTR_HI;
				default:        hdr_byte = `FRP_UNUSED;
				endcase
			end
		end
	endfunction

	// Prefetch buffer between header lookup and shifter
	wire       fifo_wr_ready;
	wire       fifo_rd_valid;
	wire [7:0] fifo_rd_data;
	wire       load_byte = (state == ST_DUMMY || state == ST_DATA) && byte_end && active;
	// Lookup stalls when the buffer is full, so the address only moves on acceptance
	wire       push      = fetch_on && fifo_wr_ready;

	// Flushed while deselected, so a cut read leaves no stale bytes
	frp_fifo #(
		.W  (8),
		.AW (3)
	) u_fifo (
		.clk_i      (CLK_SYS_I),
		.rst_i      (SYS_RST_I),
		.flush_i    (cs_n_s),
		.wr_valid_i (fetch_on),
		.wr_ready_o (fifo_wr_ready),
		.wr_data_i  (hdr_byte(fetch_addr)),
		.rd_valid_o (fifo_rd_valid),
		.rd_ready_i (load_byte),
		.rd_data_o  (fifo_rd_data)
	);

	// Frame decoding on serial clock rising edges
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state      <= ST_CMD;
			in_sr      <= 8'h00;
			bit_cnt    <= 4'h0;
			addr_cnt   <= 2'h0;
			opcode     <= `FRP_OP_NOP;
			op_ok      <= 1'b0;
			extra      <= 1'b0;
			fetch_addr <= 24'h00_0000;
			fetch_on   <= 1'b0;
		end else if (!active) begin
			// Idle between frames; read stops here at any byte position
			state    <= ST_CMD;
			bit_cnt  <= 4'h0;
			addr_cnt <= 2'h0;
			fetch_on <= 1'b0;
			// Command flags live for one frame only
			if (cs_rise) begin
				op_ok <= 1'b0;
				extra <= 1'b0;
			end
		end else begin
			if (push) begin
				fetch_addr <= fetch_addr + 24'h00_0001;
			end
			if (sck_rise) begin
				in_sr   <= next_sr;
				bit_cnt <= byte_end ? 4'h0 : next_cnt;
				case (state)
				ST_CMD: begin
					if (byte_end) begin
						opcode <= next_sr;
						op_ok  <= 1'b1;
						// Header read is a single-line command only
						if (next_sr == `FRP_OP_PREAD && !quad) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_DONE;
						end
					end
				end
				ST_ADDR: begin
					// Address arrives high byte first
					if (byte_end) begin
						fetch_addr <= {fetch_addr[15:0], next_sr};
						addr_cnt   <= addr_cnt + 2'h1;
						if (addr_cnt == `FRP_ADDR_BYTES - 2'h1) begin
							state <= ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					// Lookup starts now; the eight-entry buffer fills at one byte per system clock
					fetch_on <= 1'b1;
					if (byte_end) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					fetch_on <= 1'b1;
				end
				ST_DONE: begin
					// Clocks past the opcode spoil a plain command
					extra <= 1'b1;
				end
				default: begin
					state <= ST_CMD;
				end
				endcase
			end
		end
	end

	// Output shifter, changes on serial clock falling edges
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			out_sr   <= `FRP_UNUSED;
			out_cnt  <= 4'h0;
			SIO_O    <= 4'h0;
			SIO_OE_O <= 4'h0;
		end else if (!active) begin
			out_cnt  <= 4'h0;
			SIO_OE_O <= 4'h0;
		end else begin
			if (load_byte) begin
				// An empty buffer only happens with an overly fast clock
				out_sr  <= fifo_rd_valid ? fifo_rd_data : `FRP_UNUSED;
				out_cnt <= `FRP_BYTE_BITS;
			end else if (sck_fall && out_cnt != 4'h0) begin
				// Only the data-out line is ever driven
				SIO_O    <= {2'b00, out_sr[7], 1'b0};
				SIO_OE_O <= 4'b0010;
				out_sr   <= {out_sr[6:0], 1'b1};
				out_cnt  <= out_cnt - 4'h1;
			end
		end
	end

	// Command execution at the end of a clean one-byte frame
	wire clean   = cs_rise && op_ok && !extra && state == ST_DONE && bit_cnt == 4'h0;
	wire do_rst  = clean && opcode == `FRP_OP_RESET && armed && !ERASE_SUSP_I;
	// Any completed frame but a clean arm, including a header read, disarms
	wire any_end = cs_rise && op_ok;

	// Reset arm, four-wire mode and recovery
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			armed        <= 1'b0;
			quad         <= 1'b0;
			rcv_busy     <= 1'b0;
			rcv_cnt      <= 16'h0000;
			ABORT_O      <= 1'b0;
			RESET_DONE_O <= 1'b0;
		end else begin
			ABORT_O      <= 1'b0;
			RESET_DONE_O <= 1'b0;
			if (rcv_busy) begin
				// Frames are refused until the count runs out
				if (rcv_cnt == 16'h0001) begin
					rcv_busy     <= 1'b0;
					RESET_DONE_O <= 1'b1;
				end
				rcv_cnt <= rcv_cnt - 16'h0001;
			end else if (do_rst) begin
				// Volatile state back to power-on values
				armed    <= 1'b0;
				quad     <= 1'b0;
				rcv_busy <= 1'b1;
				// A running program or erase is given up; its data may be lost
				ABORT_O  <= PROG_BUSY_I || ERASE_BUSY_I;
				rcv_cnt  <= PROG_BUSY_I ? RCV_PROG_CYC : RCV_OTHER_CYC;
			end else if (clean && opcode == `FRP_OP_ARM) begin
				armed <= 1'b1;
			end else if (any_end) begin
				// No-operation and every other command cancel arming
				armed <= 1'b0;
				if (clean && quad && opcode == `FRP_OP_QEXIT) begin
					quad <= 1'b0;
				end
				if (clean && !quad && opcode == `FRP_OP_QENTRY) begin
					quad <= 1'b1;
				end
			end
		end
	end

	// Mode and busy flags, registered copies
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			BUSY_O      <= 1'b0;
			QUAD_MODE_O <= 1'b0;
		end else begin
			BUSY_O      <= rcv_busy;
			QUAD_MODE_O <= quad;
		end
	end
endmodule // frp_top

// ---- frp_top_chk.sv ----
/* Port checker for frp_top: reset recovery, abort, quad mode, data enable.
   Assumes a bind to frp_top, recovery of 600 or 1500 system cycles. */
`timescale 1ns/1ps
module frp_top_chk (
	// Clock and reset
	input wire       CLK_SYS_I,
	input wire       SYS_RST_I,
	// Pins and core status
	input wire       CS_N_I,
	input wire [3:0] SIO_OE_O,
	input wire       PROG_BUSY_I,
	input wire       ERASE_BUSY_I,
	// Status outputs
	input wire       ABORT_O,
	input wire       BUSY_O,
	input wire       QUAD_MODE_O,
	input wire       RESET_DONE_O
);
	reg [11:0] busy_len;
	reg        from_prog;
	// Busy length, and whether a program was running as busy rose
	always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			busy_len  <= 12'h000;
			from_prog <= 1'b0;
		end else begin
			busy_len  <= BUSY_O ? busy_len + 12'h001 : 12'h000;
			from_prog <= BUSY_O ? from_prog : PROG_BUSY_I;
		end
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	// Small tolerance for the pin synchroniser latency
	a_recovery_prog: assert property ($fell(BUSY_O) && from_prog |->
		busy_len > 12'h05D9 && busy_len < 12'h05DF) else $error("program recovery length");
	a_recovery_other: assert property ($fell(BUSY_O) && !from_prog |->
		busy_len > 12'h0255 && busy_len < 12'h025B) else $error("recovery length");
	a_abort_single: assert property (ABORT_O |=> !ABORT_O) else $error("abort width");
	a_abort_cause: assert property (ABORT_O |-> $past(PROG_BUSY_I) || $past(ERASE_BUSY_I))
		else $error("abort without operation");
	a_abort_busy: assert property (ABORT_O |-> ##[0:2] BUSY_O) else $error("abort no busy");
	a_done_single: assert property (RESET_DONE_O |=> !RESET_DONE_O) else $error("done width");
	a_busy_ends_done: assert property ($fell(BUSY_O) |-> RESET_DONE_O || $past(RESET_DONE_O) ||
		$past(RESET_DONE_O, 2)) else $error("busy ended without done");
	a_quad_cleared: assert property ($rose(BUSY_O) |-> ##[0:2] !QUAD_MODE_O)
		else $error("quad kept over reset");
	a_quiet_busy: assert property (BUSY_O |-> SIO_OE_O == 4'h0) else $error("drive in recovery");
	a_oe_data_line: assert property (SIO_OE_O == 4'h0 || SIO_OE_O == 4'h2)
		else $error("wrong line enabled");
	a_oe_drops_cs: assert property (CS_N_I [*5] |-> SIO_OE_O == 4'h0)
		else $error("drive after deselect");
	a_quad_deselect: assert property (!$stable(QUAD_MODE_O) |-> CS_N_I)
		else $error("quad changed in frame");
	// Main scenarios
	c_prog_reset: cover property ($rose(BUSY_O) && from_prog);
	c_data_out: cover property (SIO_OE_O == 4'h2);
	c_quad_on: cover property ($rose(QUAD_MODE_O));
	c_abort: cover property (ABORT_O);
endmodule // frp_top_chk
bind frp_top frp_top_chk chk_u (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .CS_N_I(CS_N_I),
	.SIO_OE_O(SIO_OE_O), .PROG_BUSY_I(PROG_BUSY_I), .ERASE_BUSY_I(ERASE_BUSY_I),
	.ABORT_O(ABORT_O), .BUSY_O(BUSY_O), .QUAD_MODE_O(QUAD_MODE_O), .RESET_DONE_O(RESET_DONE_O));

// ---- frp_host.sv ----
/* Host controller model: frames, command bytes and data reads.
   Assumes a 50 MHz clock; one serial clock period is eight cycles. */
`timescale 1ns/1ps
module frp_host (
	// System clock
	input  wire       clk_i,
	// Serial pins
	output reg        cs_n_o,
	output reg        sclk_o,
	output reg  [3:0] sio_o,
	input  wire [3:0] line_i
);
	// Serial clock stands low outside frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sio_o  = 4'h0;
	end
	task half;
		repeat (4) @(posedge clk_i);
	endtask
	// One byte, MSB first; single mode scrambles the upper lines
	task put(input q, input [7:0] b);
		integer i;
		for (i = 7; i >= 0; i = i - (q ? 4 : 1)) begin
			sio_o <= q ? b[i -: 4] : {3'($urandom), b[i]};
			half;
			sclk_o <= 1'b1;
			half;
			sclk_o <= 1'b0;
		end
	endtask
	// Sampled late in the high phase, well clear of the change
	task get(output [7:0] b);
		integer i;
		for (i = 7; i >= 0; i = i - 1) begin
			sio_o <= ~sio_o;
			half;
			sclk_o <= 1'b1;
			half;
			b[i] = line_i[1];
			sclk_o <= 1'b0;
		end
	endtask
	task open;
		cs_n_o <= 1'b0;
		half;
	endtask
	// Deselect time kept after every frame, quad entry and exit too
	task close;
		half;
		cs_n_o <= 1'b1;
		sio_o <= ~sio_o;
		repeat (5) half;
	endtask
endmodule // frp_host

// ---- tb_flash_reset_and_param_read.sv ----
/* Self-checking bench for frp_top: header reads, quad mode, software reset.
   Assumes frp_host on the pins and recovery of 600 or 1500 cycles. */
`timescale 1ns/1ps
module tb_flash_reset_and_param_read;
	reg              clk;
	reg              rst;
	reg              prog_busy;
	reg              erase_busy;
	reg              erase_susp;
	reg              cnt_clr;
	wire             cs_n;
	wire             sclk;
	wire [3:0]       host_sio;
	wire [3:0]       sio_out;
	wire [3:0]       sio_oe;
	wire [3:0]       sio_wire;
	wire             abort_p;
	wire             busy;
	wire             quad;
	wire             done;
	integer          mismatches;
	integer          tests_run;
	integer          blen;
	integer          aborts;
	integer          dones;
	integer          j;
	localparam [7:0] VID = 8'h3C; // arbitrary value
	// Line 1 belongs to the device while enabled
	assign sio_wire = {host_sio[3:2], sio_oe[1] ? sio_out[1] : host_sio[1], host_sio[0]};
	frp_host host_u (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(host_sio),
		.line_i(sio_wire));
	frp_top #(.VENDOR_ID(VID)) dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk),
		.CS_N_I(cs_n), .SIO_I(sio_wire), .SIO_O(sio_out), .SIO_OE_O(sio_oe),
		.PROG_BUSY_I(prog_busy), .ERASE_BUSY_I(erase_busy), .ERASE_SUSP_I(erase_susp),
		.ABORT_O(abort_p), .BUSY_O(busy), .QUAD_MODE_O(quad), .RESET_DONE_O(done));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Event counters for the reset cases; cleared only here, so no race
	always @(posedge clk) begin
		if (cnt_clr) begin
			blen <= 0;
			aborts <= 0;
			dones <= 0;
		end else begin
			blen <= blen + (busy === 1'b1);
			aborts <= aborts + (abort_p === 1'b1);
			dones <= dones + (done === 1'b1);
		end
	end
	task chk(input string what, input [15:0] exp, input [15:0] got);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function [7:0] exp_b(input [7:0] a);
		case (a)
			8'h00: exp_b = 8'h53;
			8'h01: exp_b = 8'h46;
			8'h02: exp_b = 8'h44;
			8'h03: exp_b = 8'h50;
			8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16: exp_b = 8'h00;
			8'h05, 8'h06, 8'h0A, 8'h12: exp_b = 8'h01;
			8'h0B: exp_b = 8'h09;
			8'h0C: exp_b = 8'h30;
			8'h10: exp_b = VID;
			8'h13: exp_b = 8'h04;
			8'h14: exp_b = 8'h60;
			default: exp_b = 8'hFF;
		endcase
	endfunction
	task cmd(input q, input [7:0] op);
		host_u.open;
		host_u.put(q, op);
		host_u.close;
	endtask
	task do_read(input [7:0] a, input [7:0] n);
		reg [7:0] k;
		reg [7:0] b;
		host_u.open;
		host_u.put(1'b0, 8'h5A);
		host_u.put(1'b0, 8'h00);
		host_u.put(1'b0, 8'h00);
		host_u.put(1'b0, a);
		host_u.put(1'b0, 8'h00);
		for (k = 8'h00; k < n; k = k + 8'h01) begin
			host_u.get(b);
			chk("read byte", exp_b(a + k), b);
			chk("data enable", 4'h2, sio_oe);
		end
		host_u.close;
		chk("enable after deselect", 4'h0, sio_oe);
	endtask
	// Arm, optional frame between, execute; then watch the recovery
	task rst_case(input q, input m, input [7:0] mid, input p, input e, input s, input x);
		integer n;
		if (q)
			cmd(1'b0, 8'h35);
		@(posedge clk);
		prog_busy <= p;
		erase_busy <= e;
		erase_susp <= s;
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		cmd(q, 8'h66);
		if (m)
			cmd(q, mid);
		cmd(q, 8'h99);
		for (n = 0; busy !== 1'b0 && n < 2000; n = n + 1)
			@(posedge clk);
		if (n == 2000) begin
			mismatches = mismatches + 1;
			summarize;
		end
		repeat (3) @(posedge clk);
		prog_busy <= 1'b0;
		erase_busy <= 1'b0;
		erase_susp <= 1'b0;
		chk("reset done", x, dones[15:0]);
		chk("abort", x & (p | e), aborts[15:0]);
		chk("recovery", x, blen > (p ? 1497 : 597) && blen < (p ? 1503 : 603));
		chk("quad after", 1'b0, quad);
		$display("test reset case done");
	endtask
	initial begin
		rst = 1'b1;
		prog_busy = 1'b0;
		erase_busy = 1'b0;
		erase_susp = 1'b0;
		mismatches = 0;
		tests_run = 0;
		cnt_clr = 1'b1;
		void'($urandom(70));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		do_read(8'h00, 8'h1A);
		for (j = 0; j < 4; j = j + 1)
			do_read(8'($urandom % 32), 8'(1 + $urandom % 4));
		$display("test header read done");
		cmd(1'b0, 8'h35);
		chk("quad entry", 1'b1, quad);
		cmd(1'b0, 8'hF5);
		chk("single exit ignored", 1'b1, quad);
		cmd(1'b1, 8'hF5);
		chk("quad exit", 1'b0, quad);
		$display("test quad mode done");
		rst_case(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		rst_case(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		rst_case(1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		rst_case(1'b0, 1'b1, 8'hA0 + 8'($urandom % 16), 1'b0, 1'b0, 1'b0, 1'b0);
		rst_case(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		rst_case(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
		rst_case(1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
		// Pin reset still works with erase suspended
		cmd(1'b0, 8'h35);
		erase_susp <= 1'b1;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		erase_susp <= 1'b0;
		repeat (4) @(posedge clk);
		chk("quad after pin reset", 1'b0, quad);
		do_read(8'h10, 8'h02);
		$display("test pin reset done");
		summarize;
	end
endmodule // tb_flash_reset_and_param_read
